// File: tb/term_model.sv
`timescale 1ns/1ps
module term_model
#(
  parameter int BIT_CYCLES = 8
)
(
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out,
  output logic      cts_n_out
);
  logic [7:0] rx_q [$];
  logic       hold_r = 1'b0;
  int         frame_errs = 0;

  // Remote side only types keys, never panel buttons
  assign cts_n_out = hold_r; // Flow control stall
  initial rxd_out = 1'b1;

  // Start, eight data bits LSB first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out = fr[i];
      repeat (BIT_CYCLES) @(negedge clk_in);
    end
    repeat (2 * BIT_CYCLES) @(negedge clk_in);
  endtask : send_byte

  // Mid-bit sampling receiver
  always
  begin
    logic [7:0] b;
    @(negedge txd_in);
    repeat (BIT_CYCLES / 2) @(negedge clk_in);
    if (txd_in === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(negedge clk_in);
        b[i] = txd_in;
      end
      repeat (BIT_CYCLES) @(negedge clk_in);
      if (txd_in !== 1'b1)
        frame_errs++;
      rx_q.push_back(b);
    end
  end
endmodule : term_model

// File: tb/tx_supervisor_tb_top.sv
`timescale 1ns/1ps
module tx_supervisor_tb_top;
  import txsup_pkg::*;
  logic                  clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  logic [15:0]           freq_switch_in = PANEL_POWER_CODE;
  logic [PWR_W-1:0]      pot_ceiling_in = 8'h05;
  logic                  panel_up_in = 1'b0;
  logic                  panel_down_in = 1'b0;
  logic                  panel_next_in = 1'b0;
  logic                  mute_n_in = 1'b1;
  logic                  fault_vswr_in = 1'b0;
  logic                  fault_temp_in = 1'b0;
  logic [2:0]            flt = 3'h0;
  logic                  rxd_in;
  logic                  cts_n_in;
  logic                  txd_out;
  logic                  rts_n_out;
  logic [PWR_W-1:0]      power_setpoint_out;
  logic                  rf_mute_out;
  logic                  not_allowed_out;
  logic [SCREEN_W-1:0]   screen_out;
  logic [2:0]            alarm_ttl_out;
  logic [2:0]            alarm_oc_out;
  logic [2:0]            alarm_oc_oe_n_out;
  int                    fails = 0;
  int                    n_tests = 0;

  always #2 clk_in = ~clk_in;

  tx_supervisor #(
    .TICK_CYCLES(10), .BIT_CYCLES(8), .MENU_TIMEOUT_TICKS(5), .ALARM_QUAL_TICKS(4),
    .CMD_WINDOW_TICKS(200)
  ) dut_u (
    .clk_in, .rst_in, .freq_switch_in, .pot_ceiling_in, .panel_up_in, .panel_down_in,
    .panel_next_in, .mute_n_in, .fault_vswr_in, .fault_temp_in, .rf_low_in(flt[0]),
    .pll_unlock_in(flt[1]), .mod_low_in(flt[2]), .rxd_in, .cts_n_in, .txd_out, .rts_n_out,
    .power_setpoint_out, .rf_mute_out, .not_allowed_out, .screen_out, .alarm_ttl_out,
    .alarm_oc_out, .alarm_oc_oe_n_out
  );
  term_model term_u (
    .clk_in, .txd_in(txd_out), .rxd_out(rxd_in), .cts_n_out(cts_n_in)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
      fails++;
    end
  endtask : chk
  task automatic give_verdict;
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic send(input logic [7:0] b);
    term_u.send_byte(b);
    cyc(4);
  endtask : send
  task automatic wait_rx(input int n);
    for (int i = 0; i < 1500 && term_u.rx_q.size() < n; i++)
      cyc(1);
    if (term_u.rx_q.size() < n)
    begin
      fails++;
      give_verdict();
    end
  endtask : wait_rx
  task automatic status(input logic [2:0] exp);
    term_u.rx_q.delete();
    send(KEY_ENTER);
    wait_rx(4);
    for (int i = 0; i < 3; i++)
      chk("status", term_u.rx_q[i], CHAR_ZERO | {7'h00, exp[i]});
    chk("status end", term_u.rx_q[3], CHAR_CR);
  endtask : status
  task automatic do_reset;
    rst_in = 1'b1;
    cyc(4);
    rst_in = 1'b0;
    cyc(1);
    chk("reset state", {power_setpoint_out, alarm_ttl_out, screen_out}, 14'h0);
    chk("oc reset", {alarm_oc_out, alarm_oc_oe_n_out}, 6'h07);
    chk("link idle", {txd_out, rts_n_out}, 2'b10);
  endtask : do_reset
  task automatic t_panel;
    repeat (8) pulse(panel_up_in);
    cyc(3);
    chk("ceiling", power_setpoint_out, 8'h05);
    pulse(panel_down_in);
    cyc(3);
    chk("panel down", power_setpoint_out, 8'h04);
    freq_switch_in = 16'h1234;
    cyc(3);
    panel_up_in = 1'b1;
    cyc(1);
    panel_up_in = 1'b0;
    chk("refused", not_allowed_out, 1'b1);
    cyc(3);
    chk("pot only", {not_allowed_out, power_setpoint_out}, 9'h005);
  endtask : t_panel
  task automatic t_fault;
    fault_vswr_in = 1'b1;
    cyc(5);
    chk("vswr cut", power_setpoint_out, 8'h02);
    fault_vswr_in = 1'b0;
    fault_temp_in = 1'b1;
    cyc(5);
    chk("heat cut", power_setpoint_out, 8'h02);
    fault_temp_in = 1'b0;
    cyc(5);
    chk("recover", power_setpoint_out, 8'h05);
    mute_n_in = 1'b0;
    cyc(5);
    chk("pin mute", {rf_mute_out, power_setpoint_out}, 9'h100);
    mute_n_in = 1'b1;
    cyc(5);
    chk("pin unmute", {rf_mute_out, power_setpoint_out}, 9'h005);
  endtask : t_fault
  task automatic t_serial;
    pot_ceiling_in = 8'h02;
    send(KEY_MUTE);
    chk("locked", {rf_mute_out, 8'(term_u.rx_q.size())}, 9'h000);
    status(3'h0);
    send(KEY_MUTE);
    chk("mute key", rf_mute_out, 1'b1);
    send(KEY_UNMUTE);
    chk("unmute key", rf_mute_out, 1'b0);
    send(KEY_PWR_UP);
    chk("remote up", power_setpoint_out, 8'h05);
    send(KEY_PWR_DN);
    chk("remote down", power_setpoint_out, 8'h04);
    term_u.hold_r = 1'b1;
    term_u.rx_q.delete();
    send(KEY_ENTER);
    cyc(300);
    chk("flow held", term_u.rx_q.size(), 0);
    term_u.hold_r = 1'b0;
    wait_rx(4);
    chk("frames", term_u.frame_errs, 0);
  endtask : t_serial
  task automatic t_alarms;
    freq_switch_in = PANEL_POWER_CODE;
    flt = 3'b001;
    cyc(20);
    chk("rf early", alarm_ttl_out, 3'h0);
    cyc(40);
    chk("rf alarm", alarm_ttl_out, 3'h1);
    flt = 3'b010;
    cyc(28);
    flt = 3'b000;
    cyc(3);
    flt = 3'b010;
    cyc(28);
    chk("pll restart", alarm_ttl_out, 3'h1);
    cyc(40);
    chk("pll alarm", alarm_ttl_out, 3'h3);
    flt = 3'b100;
    cyc(60);
    flt = 3'b000;
    cyc(5);
    chk("latched", {alarm_ttl_out, alarm_oc_oe_n_out}, 6'h38);
    status(3'h7);
    send(KEY_ALM_RST);
    chk("clear key", alarm_ttl_out, 3'h0);
    flt = 3'b001;
    cyc(60);
    flt = 3'b000;
    chk("rf again", alarm_ttl_out, 3'h1);
    do_reset();
  endtask : t_alarms
  task automatic t_menu;
    pulse(panel_next_in);
    chk("next screen", screen_out, 3'h1);
    cyc(40);
    chk("menu held", screen_out, 3'h1);
    cyc(60);
    chk("menu back", screen_out, 3'h0);
  endtask : t_menu

  initial
  begin
    do_reset();
    t_panel();
    t_fault();
    t_serial();
    t_alarms();
    t_menu();
    give_verdict();
  end
endmodule : tx_supervisor_tb_top

// File: tb/txsup_chk.sv
`timescale 1ns/1ps
module txsup_chk
  import txsup_pkg::*;
#(
  parameter int TICK_CYCLES        = 10,
  parameter int MENU_TIMEOUT_TICKS = 5,
  parameter int ALARM_QUAL_TICKS   = 4
)
(
  // Clock, reset and inputs
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic [15:0]           freq_switch_in,
  input wire logic [PWR_W-1:0]      pot_ceiling_in,
  input wire logic                  panel_up_in,
  input wire logic                  panel_down_in,
  input wire logic                  panel_next_in,
  input wire logic                  mute_n_in,
  input wire logic                  rf_low_in,
  input wire logic                  pll_unlock_in,
  input wire logic                  mod_low_in,
  // Outputs
  input wire logic [PWR_W-1:0]      power_setpoint_out,
  input wire logic                  rf_mute_out,
  input wire logic                  not_allowed_out,
  input wire logic [SCREEN_W-1:0]   screen_out,
  input wire logic [NUM_ALARMS-1:0] alarm_ttl_out,
  input wire logic [NUM_ALARMS-1:0] alarm_oc_out,
  input wire logic [NUM_ALARMS-1:0] alarm_oc_oe_n_out
);
  localparam int QUAL_MIN = (ALARM_QUAL_TICKS - 1) * TICK_CYCLES - 2;
  localparam int QUAL_MAX = (ALARM_QUAL_TICKS + 1) * TICK_CYCLES + 4;
  localparam int MENU_MAX = (MENU_TIMEOUT_TICKS + 2) * TICK_CYCLES + 3;
  logic [2:0] flt1_r;
  logic [2:0] flt2_r;
  logic [2:0] alm_r;
  logic [2:0] early;
  int         run_r [3];
  int         norm_r;
  int         menu_r;

  // Fault lanes delayed like the synchroniser
  always_ff @(posedge clk_in)
  begin
    flt1_r <= rst_in ? 3'h0 : {mod_low_in, pll_unlock_in, rf_low_in};
    flt2_r <= rst_in ? 3'h0 : flt1_r;
    alm_r  <= rst_in ? 3'h0 : alarm_ttl_out;
  end
  // Run lengths of faults and menu dwell
  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < 3; i++)
    begin
      run_r[i] <= (rst_in || !flt2_r[i]) ? 0 : ((run_r[i] < QUAL_MAX) ? run_r[i] + 1 : QUAL_MAX);
    end
    norm_r <= (rst_in || !flt2_r[0] || screen_out != DEFAULT_SCREEN || rf_mute_out) ? 0 :
              ((norm_r < QUAL_MAX) ? norm_r + 1 : QUAL_MAX);
    menu_r <= (rst_in || screen_out == DEFAULT_SCREEN || panel_next_in) ? 0 :
              ((menu_r <= MENU_MAX) ? menu_r + 1 : menu_r);
  end
  assign early = {run_r[2] < QUAL_MIN, run_r[1] < QUAL_MIN, run_r[0] < QUAL_MIN};

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_refused_key;
    (panel_up_in || panel_down_in) && freq_switch_in != PANEL_POWER_CODE;
  endsequence
  sequence s_pin_low;
    !mute_n_in [*3];
  endsequence
  sequence s_panel_steady;
    (freq_switch_in == PANEL_POWER_CODE && $stable(pot_ceiling_in)) [*3];
  endsequence

  property p_refuse;
    s_refused_key |=> not_allowed_out;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused key gave no warning pulse");
  property p_ceiling;
    s_panel_steady |-> power_setpoint_out <= pot_ceiling_in;
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("panel setpoint above ceiling");
  property p_pin_mute;
    s_pin_low |-> rf_mute_out;
  endproperty
  a_pin_mute: assert property (p_pin_mute)
    else $error("low mute pin did not mute");
  property p_mute_zero;
    rf_mute_out [*3] |-> power_setpoint_out == 8'h00;
  endproperty
  a_mute_zero: assert property (p_mute_zero)
    else $error("power present while muted");
  property p_oc_mirror;
    alarm_oc_oe_n_out == ~alarm_ttl_out && alarm_oc_out == 3'h0;
  endproperty
  a_oc_mirror: assert property (p_oc_mirror)
    else $error("open collector disagrees with alarm");
  property p_alarm_qual;
    |(alarm_ttl_out & ~alm_r) |-> !(|(alarm_ttl_out & ~alm_r & early));
  endproperty
  a_alarm_qual: assert property (p_alarm_qual)
    else $error("alarm raised before qualification time");
  property p_alarm_set;
    norm_r >= QUAL_MAX |-> alarm_ttl_out[ALM_RF];
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("power alarm missing after long fault");
  property p_alarm_latch;
    |($past(alarm_ttl_out) & ~alarm_ttl_out) |-> alarm_ttl_out == 3'h0;
  endproperty
  a_alarm_latch: assert property (p_alarm_latch)
    else $error("single alarm dropped");
  property p_menu;
    menu_r <= MENU_MAX;
  endproperty
  a_menu: assert property (p_menu)
    else $error("menu did not return to default");
  property p_release;
    $fell(rst_in) |-> alarm_ttl_out == 3'h0 && power_setpoint_out == 8'h00 && screen_out == 3'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("state not cleared by reset");
endmodule : txsup_chk

bind tx_supervisor txsup_chk #(
  .TICK_CYCLES       (TICK_CYCLES),
  .MENU_TIMEOUT_TICKS(MENU_TIMEOUT_TICKS),
  .ALARM_QUAL_TICKS  (ALARM_QUAL_TICKS)
) chk_u (
  .clk_in, .rst_in, .freq_switch_in, .pot_ceiling_in, .panel_up_in, .panel_down_in,
  .panel_next_in, .mute_n_in, .rf_low_in, .pll_unlock_in, .mod_low_in, .power_setpoint_out,
  .rf_mute_out, .not_allowed_out, .screen_out, .alarm_ttl_out, .alarm_oc_out, .alarm_oc_oe_n_out
);

// File: verilog/serial_if.sv
`timescale 1ns/1ps
interface serial_if;
  logic       rx_line;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_start;
  logic [7:0] tx_data;
  logic       tx_busy;
  logic       tx_line;

  modport link (
    input  rx_line,
    input  tx_start,
    input  tx_data,
    output rx_valid,
    output rx_data,
    output tx_busy,
    output tx_line
  );

  modport ctrl (
    output rx_line,
    output tx_start,
    output tx_data,
    input  rx_valid,
    input  rx_data,
    input  tx_busy,
    input  tx_line
  );
endinterface : serial_if

// File: verilog/tx_supervisor.sv
`timescale 1ns/1ps
// How it works
// - Panel power keys only with switch code 4440
// - Serial power keys work with any switch code
// - Panel power never exceeds potentiometer ceiling
// - Reflected-power or heat fault cuts power
// - Low rear mute pin mutes RF
// - Key o mutes, key f unmutes
// - Menu returns to default after 5 minutes
// - RF low sixty seconds raises alarm
// - Unlock sixty seconds raises lock alarm
// - Deviation under 16 kHz sixty seconds alarms
// - Alarms latch until reset or clear key
// - Logic output high, open collector low
// - Alarm states sent over serial link
// - Link runs 9600 8N1 with flow control
// - Enter opens 60 s key window, refreshes
// - Key 6 clears all three alarms
module tx_supervisor
  import txsup_pkg::*;
#(
  parameter int TICK_CYCLES        = TICK_CYCLES_DEF,
  parameter int BIT_CYCLES         = BIT_CYCLES_DEF,
  parameter int MENU_TIMEOUT_TICKS = MENU_TIMEOUT_TICKS_DEF,
  parameter int ALARM_QUAL_TICKS   = ALARM_QUAL_TICKS_DEF,
  parameter int CMD_WINDOW_TICKS   = CMD_WINDOW_TICKS_DEF
)
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Internal switches and potentiometer
  input  wire logic [15:0]           freq_switch_in,
  input  wire logic [PWR_W-1:0]      pot_ceiling_in,
  // Front panel, one-cycle pulses
  input  wire logic                  panel_up_in,
  input  wire logic                  panel_down_in,
  input  wire logic                  panel_next_in,
  // Sensor and rear pins
  input  wire logic                  mute_n_in,
  input  wire logic                  fault_vswr_in,
  input  wire logic                  fault_temp_in,
  input  wire logic                  rf_low_in,
  input  wire logic                  pll_unlock_in,
  input  wire logic                  mod_low_in,
  // Serial link
  input  wire logic                  rxd_in,
  input  wire logic                  cts_n_in,
  output logic                       txd_out,
  output logic                       rts_n_out,
  // Power control
  output logic [PWR_W-1:0]           power_setpoint_out,
  output logic                       rf_mute_out,
  output logic                       not_allowed_out,
  output logic [SCREEN_W-1:0]        screen_out,
  // Alarm outputs
  output logic [NUM_ALARMS-1:0]      alarm_ttl_out,
  output logic [NUM_ALARMS-1:0]      alarm_oc_out,
  output logic [NUM_ALARMS-1:0]      alarm_oc_oe_n_out
);
  import txsup_pkg::*;

  serial_if sif ();

  logic [SYNC_W-1:0]     sync1_r;
  logic [SYNC_W-1:0]     sync2_r;
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic                  tick_r;
  logic [SCREEN_W-1:0]   screen_r;
  logic [MS_CNT_W-1:0]   menu_cnt_r;
  logic [MS_CNT_W-1:0]   window_cnt_r;
  logic                  mute_cmd_r;
  logic                  remote_r;
  logic [PWR_W-1:0]      level_r;
  logic [PWR_W-1:0]      setpoint_nxt;
  logic [PWR_W-1:0]      setpoint_r;
  logic                  not_allowed_r;
  logic [NUM_ALARMS-1:0] fault_cond;
  logic [NUM_ALARMS-1:0] alarm_set;
  logic [NUM_ALARMS-1:0] alarm_r;
  status_state_t         st_state_r;
  logic [STATUS_IDX_W-1:0] st_idx_r;
  logic [7:0]            st_byte;
  logic                  st_start;
  logic                  key_ok;
  logic                  panel_mode;
  logic                  rf_mute;
  logic                  normal_op;
  logic                  alarm_clr;

  uart_link #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_link (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .bus    (sif.link)
  );

  // Pin synchronisers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end
    else
    begin
      sync1_r <= {rxd_in, cts_n_in, mute_n_in, fault_vswr_in,
                  fault_temp_in, rf_low_in, pll_unlock_in, mod_low_in};
      sync2_r <= sync1_r;
    end
  end

  // 1 ms tick
  always_ff @(posedge clk_in)
  begin
    if (rst_in || tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1))
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    tick_r <= !rst_in && tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1);
  end

  assign sif.rx_line = sync2_r[S_RX];
  assign key_ok      = sif.rx_valid && window_cnt_r != '0;
  assign panel_mode  = freq_switch_in == PANEL_POWER_CODE;
  assign alarm_clr   = key_ok && key_is(sif.rx_data, KEY_ALM_RST);

  // Menu screen and timeout
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      screen_r   <= DEFAULT_SCREEN;
      menu_cnt_r <= '0;
    end
    else if (panel_next_in)
    begin
      screen_r   <= (screen_r == LAST_SCREEN) ? DEFAULT_SCREEN : screen_r + 1'b1;
      menu_cnt_r <= '0;
    end
    else if (screen_r == DEFAULT_SCREEN)
      menu_cnt_r <= '0;
    else if (tick_r)
    begin
      if (menu_cnt_r == MS_CNT_W'(MENU_TIMEOUT_TICKS))
      begin
        screen_r   <= DEFAULT_SCREEN;
        menu_cnt_r <= '0;
      end
      else
        menu_cnt_r <= menu_cnt_r + 1'b1;
    end
  end

  // Key window opened by Enter
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      window_cnt_r <= '0;
    else if (sif.rx_valid && key_is(sif.rx_data, KEY_ENTER))
      window_cnt_r <= MS_CNT_W'(CMD_WINDOW_TICKS);
    else if (tick_r && window_cnt_r != '0)
      window_cnt_r <= window_cnt_r - 1'b1;
  end

  // Serial mute commands
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mute_cmd_r <= 1'b0;
    else if (key_ok && key_is(sif.rx_data, KEY_MUTE))
      mute_cmd_r <= 1'b1;
    else if (key_ok && key_is(sif.rx_data, KEY_UNMUTE))
      mute_cmd_r <= 1'b0;
  end

  assign rf_mute = mute_cmd_r || !sync2_r[S_MUTE_N];

  // Digital power level
  always_ff @(posedge clk_in)
  begin
    not_allowed_r <= 1'b0;
    if (rst_in)
    begin
      level_r  <= PWR_RESET;
      remote_r <= 1'b0;
    end
    else if (key_ok && key_is(sif.rx_data, KEY_PWR_UP))
    begin
      remote_r <= 1'b1;
      if (level_r != PWR_MAX)
        level_r <= level_r + 1'b1;
    end
    else if (key_ok && key_is(sif.rx_data, KEY_PWR_DN))
    begin
      remote_r <= 1'b1;
      if (level_r != '0)
        level_r <= level_r - 1'b1;
    end
    else if (panel_up_in || panel_down_in)
    begin
      if (!panel_mode)
        not_allowed_r <= 1'b1;
      else if (panel_up_in && level_r < pot_ceiling_in)
        level_r <= level_r + 1'b1;
      else if (panel_down_in && level_r != '0)
        level_r <= level_r - 1'b1;
    end
  end

  // Power setpoint selection
  always_comb
  begin
    if (panel_mode)
      setpoint_nxt = (level_r < pot_ceiling_in) ? level_r : pot_ceiling_in;
    else if (remote_r)
      setpoint_nxt = level_r;
    else
      setpoint_nxt = pot_ceiling_in;
    if (sync2_r[S_VSWR] || sync2_r[S_TEMP])
      setpoint_nxt = setpoint_nxt >> FAULT_SHIFT;
    if (rf_mute)
      setpoint_nxt = '0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      setpoint_r <= PWR_RESET;
    else
      setpoint_r <= setpoint_nxt;
  end

  // Alarm qualification and latching
  assign normal_op = screen_r == DEFAULT_SCREEN && !rf_mute;
  assign fault_cond[ALM_RF]  = sync2_r[S_RF_LOW];
  assign fault_cond[ALM_PLL] = sync2_r[S_UNLOCK];
  assign fault_cond[ALM_MOD] = sync2_r[S_MOD_LOW];

  generate
    for (genvar i = 0; i < NUM_ALARMS; i++)
    begin : g_alarm
      logic [MS_CNT_W-1:0] qual_cnt_r;

      always_ff @(posedge clk_in)
      begin
        if (rst_in || !fault_cond[i] || !normal_op)
          qual_cnt_r <= '0;
        else if (tick_r && qual_cnt_r != MS_CNT_W'(ALARM_QUAL_TICKS + 1))
          qual_cnt_r <= qual_cnt_r + 1'b1;
      end

      assign alarm_set[i] = fault_cond[i] && normal_op &&
                            qual_cnt_r == MS_CNT_W'(ALARM_QUAL_TICKS + 1);

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          alarm_r[i] <= 1'b0;
        else if (alarm_set[i])
          alarm_r[i] <= 1'b1;
        else if (alarm_clr)
          alarm_r[i] <= 1'b0;
      end
    end
  endgenerate

  // Status refresh: three alarm digits then CR
  always_comb
  begin
    if (st_idx_r == STATUS_IDX_W'(STATUS_LEN - 1))
      st_byte = CHAR_CR;
    else
      st_byte = CHAR_ZERO | {7'h00, alarm_r[st_idx_r]};
  end

  assign st_start = st_state_r == ST_SEND && !sif.tx_busy && !sync2_r[S_CTS_N];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_state_r <= ST_IDLE;
      st_idx_r   <= '0;
    end
    else
    begin
      case (st_state_r)
        ST_IDLE:
          if (sif.rx_valid && key_is(sif.rx_data, KEY_ENTER))
          begin
            st_idx_r   <= '0;
            st_state_r <= ST_SEND;
          end
        ST_SEND:
          if (st_start)
            st_state_r <= ST_WAIT;
        ST_WAIT:
          if (!sif.tx_busy)
          begin
            st_idx_r   <= st_idx_r + 1'b1;
            st_state_r <= (st_idx_r == STATUS_IDX_W'(STATUS_LEN - 1)) ? ST_IDLE : ST_SEND;
          end
        default:
          st_state_r <= ST_IDLE;
      endcase
    end
  end

  assign sif.tx_start = st_start;
  assign sif.tx_data  = st_byte;

  // Outputs
  assign txd_out            = sif.tx_line;
  assign rts_n_out          = rst_in;
  assign power_setpoint_out = setpoint_r;
  assign rf_mute_out        = rf_mute;
  assign not_allowed_out    = not_allowed_r;
  assign screen_out         = screen_r;
  assign alarm_ttl_out      = alarm_r;
  assign alarm_oc_out       = '0;
  assign alarm_oc_oe_n_out  = ~alarm_r;

endmodule : tx_supervisor

// File: verilog/txsup_pkg.sv
package txsup_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS   = 4;
  localparam int TICK_PERIOD_NS  = 1_000_000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W      = 18;

  // Serial link: 9600 8N1
  localparam int BAUD_RATE       = 9600;
  localparam int NS_PER_S        = 1_000_000_000;
  localparam int BIT_CYCLES_DEF  = NS_PER_S / (CLK_PERIOD_NS * BAUD_RATE);
  localparam int BIT_CNT_W       = 16;
  localparam int DATA_BITS       = 8;
  localparam int FRAME_BITS      = 10;

  // Long timers, counted in 1 ms ticks
  localparam int MS_PER_S        = 1000;
  localparam int S_PER_MIN       = 60;
  localparam int MENU_TIMEOUT_MIN = 5;
  localparam int ALARM_QUAL_S    = 60;
  localparam int CMD_WINDOW_S    = 60;
  localparam int MENU_TIMEOUT_TICKS_DEF = MENU_TIMEOUT_MIN * S_PER_MIN * MS_PER_S;
  localparam int ALARM_QUAL_TICKS_DEF   = ALARM_QUAL_S * MS_PER_S;
  localparam int CMD_WINDOW_TICKS_DEF   = CMD_WINDOW_S * MS_PER_S;
  localparam int MS_CNT_W        = 20;

  // Switch code that allows panel power control
  localparam logic [15:0] PANEL_POWER_CODE = 16'h4440;

  // Power setting
  localparam int PWR_W           = 8;
  localparam logic [PWR_W-1:0] PWR_MAX   = 8'hFF;
  localparam logic [PWR_W-1:0] PWR_RESET = 8'h00;
  localparam int FAULT_SHIFT     = 1;

  // Menu screens
  localparam int SCREEN_W        = 3;
  localparam logic [SCREEN_W-1:0] DEFAULT_SCREEN = 3'h0;
  localparam logic [SCREEN_W-1:0] LAST_SCREEN    = 3'h6;

  // Alarms
  localparam int NUM_ALARMS      = 3;
  localparam int ALM_RF          = 0;
  localparam int ALM_PLL         = 1;
  localparam int ALM_MOD         = 2;

  // Serial keys and status characters
  localparam logic [7:0] KEY_ENTER   = 8'h0D;
  localparam logic [7:0] KEY_PWR_UP  = 8'h33;
  localparam logic [7:0] KEY_PWR_DN  = 8'h34;
  localparam logic [7:0] KEY_ALM_RST = 8'h36;
  localparam logic [7:0] KEY_MUTE    = 8'h6F;
  localparam logic [7:0] KEY_UNMUTE  = 8'h66;
  localparam logic [7:0] CHAR_ZERO   = 8'h30;
  localparam logic [7:0] CHAR_CR     = 8'h0D;
  localparam int STATUS_LEN      = 4;
  localparam int STATUS_IDX_W    = 2;

  // Pin synchroniser lanes
  localparam int SYNC_W          = 8;
  localparam int S_RX            = 7;
  localparam int S_CTS_N         = 6;
  localparam int S_MUTE_N        = 5;
  localparam int S_VSWR          = 4;
  localparam int S_TEMP          = 3;
  localparam int S_RF_LOW        = 2;
  localparam int S_UNLOCK        = 1;
  localparam int S_MOD_LOW       = 0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'hA0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } status_state_t;

  typedef enum logic [1:0] {
    U_IDLE  = 2'b00,
    U_START = 2'b01,
    U_DATA  = 2'b10,
    U_STOP  = 2'b11
  } uart_state_t;

  function automatic logic key_is(input logic [7:0] data, input logic [7:0] key);
    key_is = (data == key);
  endfunction : key_is

endpackage : txsup_pkg

// File: verilog/uart_link.sv
`timescale 1ns/1ps
module uart_link
  import txsup_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Byte side
  serial_if.link    bus
);
  import txsup_pkg::*;

  localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(BIT_CYCLES - 1);
  localparam logic [BIT_CNT_W-1:0] HALF_LAST = BIT_CNT_W'(BIT_CYCLES / 2 - 1);

  uart_state_t          rx_state_r;
  logic [BIT_CNT_W-1:0] rx_cnt_r;
  logic [2:0]           rx_idx_r;
  logic [7:0]           rx_shift_r;
  logic                 rx_valid_r;
  logic [BIT_CNT_W-1:0] tx_cnt_r;
  logic [3:0]           tx_idx_r;
  logic [FRAME_BITS-1:0] tx_shift_r;
  logic                 tx_busy_r;

  // Receiver, mid-bit sampling
  always_ff @(posedge clk_in)
  begin
    rx_valid_r <= 1'b0;
    if (rst_in)
    begin
      rx_state_r <= U_IDLE;
      rx_cnt_r   <= '0;
      rx_idx_r   <= '0;
      rx_shift_r <= '0;
    end
    else
    begin
      rx_cnt_r <= rx_cnt_r + 1'b1;
      case (rx_state_r)
        U_IDLE:
        begin
          rx_cnt_r <= '0;
          if (!bus.rx_line)
            rx_state_r <= U_START;
        end
        U_START:
          if (rx_cnt_r == HALF_LAST)
          begin
            rx_cnt_r   <= '0;
            rx_idx_r   <= '0;
            rx_state_r <= bus.rx_line ? U_IDLE : U_DATA;
          end
        U_DATA:
          if (rx_cnt_r == BIT_LAST)
          begin
            rx_cnt_r   <= '0;
            rx_shift_r <= {bus.rx_line, rx_shift_r[7:1]};
            rx_idx_r   <= rx_idx_r + 1'b1;
            if (rx_idx_r == 3'(DATA_BITS - 1))
              rx_state_r <= U_STOP;
          end
        U_STOP:
          if (rx_cnt_r == BIT_LAST)
          begin
            rx_valid_r <= bus.rx_line;
            rx_state_r <= U_IDLE;
          end
        default:
          rx_state_r <= U_IDLE;
      endcase
    end
  end

  // Transmitter, 8N1
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_cnt_r   <= '0;
      tx_idx_r   <= '0;
      tx_shift_r <= '1;
      tx_busy_r  <= 1'b0;
    end
    else if (!tx_busy_r)
    begin
      if (bus.tx_start)
      begin
        tx_shift_r <= {1'b1, bus.tx_data, 1'b0};
        tx_cnt_r   <= '0;
        tx_idx_r   <= '0;
        tx_busy_r  <= 1'b1;
      end
    end
    else if (tx_cnt_r == BIT_LAST)
    begin
      tx_cnt_r   <= '0;
      tx_shift_r <= {1'b1, tx_shift_r[FRAME_BITS-1:1]};
      tx_idx_r   <= tx_idx_r + 1'b1;
      if (tx_idx_r == 4'(FRAME_BITS - 1))
        tx_busy_r <= 1'b0;
    end
    else
      tx_cnt_r <= tx_cnt_r + 1'b1;
  end

  assign bus.rx_valid = rx_valid_r;
  assign bus.rx_data  = rx_shift_r;
  assign bus.tx_busy  = tx_busy_r;
  assign bus.tx_line  = tx_busy_r ? tx_shift_r[0] : 1'b1;

endmodule : uart_link
